// ==== hw/aoc_output_config.sv ====
//
// Behaviour
// - Two-bit drive codes for data and clock outputs select one to four stripes.
// - Three-bit phase field gives input clock cycles of output clock delay.
// - Divided clock: phase picks divider output phase; sampling strobe stays unaffected.
// - Clock and data delay enables share a three-bit code, 0.56 to 4.48 ns.
// - First user pattern is low byte 0x19 and high byte 0x1A, reset zero.
// - Second user pattern is low byte 0x1B and high byte 0x1C, reset zero.
// - Pin function bit 0 selects mode input or overrange output, overrange at reset.
// - Low rate control resets to 0x08, slow clock detection enabled.
// - Run bit forces the low rate oscillator on, overriding the detector.
// - Bit 0 of low rate control disables the serial data pin pull-down.
//
`timescale 1ns/1ps
`default_nettype none
module aoc_output_config
    import aoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [2:0] div_ratio,
    input wire logic io_supply_1v8,
    input wire logic overrange,
    input wire logic slow_clock_detected,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic mode_in,
    output logic sample_strobe,
    output logic output_sample_clock,
    output logic [2:0] clk_drive_stripes,
    output logic [2:0] data_drive_stripes,
    output logic [12:0] clk_delay_ps,
    output logic [12:0] data_delay_ps,
    output logic [15:0] pattern_one,
    output logic [15:0] pattern_two,
    output logic detect_enable,
    output logic low_rate_oscillator,
    output logic sdio_pulldown_en
);

    aoc_state_t st;
    aoc_state_t next_st;
    logic ph_sample;
    logic ph_out;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] stripes(input logic [1:0] code);
        return {1'b0, code} + 3'h1;
    endfunction

    function automatic logic [12:0] delay_ps(input logic en, input logic [2:0] code);
        logic [12:0] steps;
        steps = {10'h000, code} + 13'h0001;
        return en ? 13'(steps * DELAY_STEP_PS) : 13'h0000;
    endfunction

    function automatic logic [7:0] read_reg(input aoc_regs_t r, input logic [12:0] a);
        case (a)
            ADDR_DRIVE: read_reg = r.drive;
            ADDR_PHASE: read_reg = r.phase;
            ADDR_DELAY: read_reg = r.delay;
            ADDR_PAT1_LO: read_reg = r.pat1_lo;
            ADDR_PAT1_HI: read_reg = r.pat1_hi;
            ADDR_PAT2_LO: read_reg = r.pat2_lo;
            ADDR_PAT2_HI: read_reg = r.pat2_hi;
            ADDR_PIN_FUNC: read_reg = r.pin_func;
            ADDR_LOW_RATE: read_reg = r.low_rate;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Clock phase selection
    // ------------------------------------------------------------
    aoc_phase_sel u_phase (
        .clk(clk),
        .rst(rst),
        .div_ratio(div_ratio),
        .phase(st.regs.phase[2:0]),
        .sample_en(ph_sample),
        .out_en(ph_out)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Registers keep their value unless the exact offset is written.
        if (reg_wr) begin
            case (reg_addr)
                ADDR_DRIVE: next_st.regs.drive = reg_wdata;
                ADDR_PHASE: next_st.regs.phase = reg_wdata & MASK_PHASE;
                ADDR_DELAY: next_st.regs.delay = reg_wdata & MASK_DELAY;
                ADDR_PAT1_LO: next_st.regs.pat1_lo = reg_wdata;
                ADDR_PAT1_HI: next_st.regs.pat1_hi = reg_wdata;
                ADDR_PAT2_LO: next_st.regs.pat2_lo = reg_wdata;
                ADDR_PAT2_HI: next_st.regs.pat2_hi = reg_wdata;
                ADDR_PIN_FUNC: next_st.regs.pin_func = reg_wdata & MASK_PIN_FUNC;
                ADDR_LOW_RATE: next_st.regs.low_rate = reg_wdata & MASK_LOW_RATE;
                default: next_st.regs = st.regs;
            endcase
        end
        // A read in the same cycle as a write returns the old value.
        next_st.rvalid = reg_rd;
        next_st.rdata = reg_rd ? read_reg(st.regs, reg_addr) : 8'h00;

        // Both pin-side inputs are asynchronous to clk.
        next_st.pin_sync = {st.pin_sync[0], pin_in};
        next_st.slow_sync = {st.slow_sync[0], slow_clock_detected};

        // Pin drives overrange when the bit is set, else it is sampled as mode.
        next_st.pin_oe = st.regs.pin_func[PIN_OVERRANGE];
        next_st.pin_out = st.regs.pin_func[PIN_OVERRANGE] & overrange;
        next_st.mode_in = ~st.regs.pin_func[PIN_OVERRANGE] & st.pin_sync[1];

        // Run forces the oscillator on whatever the detector says.
        next_st.osc_on = st.regs.low_rate[LR_RUN] | (st.regs.low_rate[LR_DETECT_EN] & st.slow_sync[1]);

        next_st.sample_strobe = ph_sample;
        next_st.out_clk = ph_out ^ st.regs.phase[PH_POLARITY];

        // Supply selects which pair of drive fields is in force.
        if (io_supply_1v8) begin
            next_st.clk_stripes = stripes(st.regs.drive[DRV_CLK_1V8 +: 2]);
            next_st.data_stripes = stripes(st.regs.drive[DRV_DATA_1V8 +: 2]);
        end else begin
            next_st.clk_stripes = stripes(st.regs.drive[DRV_CLK_3V3 +: 2]);
            next_st.data_stripes = stripes(st.regs.drive[DRV_DATA_3V3 +: 2]);
        end

        // Fine delay only retimes the pads; the sampling strobe never sees it.
        next_st.clk_delay_ps = delay_ps(st.regs.delay[DLY_CLK_EN], st.regs.delay[2:0]);
        next_st.data_delay_ps = delay_ps(st.regs.delay[DLY_DATA_EN], st.regs.delay[2:0]);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.regs.drive <= RST_DRIVE;
            st.regs.phase <= RST_PHASE;
            st.regs.delay <= RST_DELAY;
            st.regs.pat1_lo <= RST_PATTERN;
            st.regs.pat1_hi <= RST_PATTERN;
            st.regs.pat2_lo <= RST_PATTERN;
            st.regs.pat2_hi <= RST_PATTERN;
            st.regs.pin_func <= RST_PIN_FUNC;
            st.regs.low_rate <= RST_LOW_RATE;
            st.clk_stripes <= 3'h1;
            st.data_stripes <= 3'h1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign pin_out = st.pin_out;
    assign pin_oe = st.pin_oe;
    assign mode_in = st.mode_in;
    assign sample_strobe = st.sample_strobe;
    assign output_sample_clock = st.out_clk;
    assign clk_drive_stripes = st.clk_stripes;
    assign data_drive_stripes = st.data_stripes;
    assign clk_delay_ps = st.clk_delay_ps;
    assign data_delay_ps = st.data_delay_ps;
    assign pattern_one = {st.regs.pat1_hi, st.regs.pat1_lo};
    assign pattern_two = {st.regs.pat2_hi, st.regs.pat2_lo};
    assign detect_enable = st.regs.low_rate[LR_DETECT_EN];
    assign low_rate_oscillator = st.osc_on;
    assign sdio_pulldown_en = ~st.regs.low_rate[LR_PULLDOWN_OFF];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence wr_seq(logic [12:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence rd_seq(logic [12:0] a);
        reg_rd && !reg_wr && reg_addr == a;
    endsequence

    drive_code_a: assert property (wr_seq(ADDR_DRIVE) ##0 (reg_wdata[1:0] == 2'h3 && io_supply_1v8)
        ##1 io_supply_1v8 |=> data_drive_stripes == 3'h4)
        else $error("Drive code three did not give four stripes.");
    pat_one_a: assert property (wr_seq(ADDR_PAT1_HI) ##1 wr_seq(ADDR_PAT1_LO)
        |=> pattern_one == {$past(reg_wdata, 2), $past(reg_wdata)})
        else $error("First pattern not assembled from its two bytes.");
    pat_two_a: assert property (wr_seq(ADDR_PAT2_LO) |=> pattern_two[7:0] == $past(reg_wdata))
        else $error("Second pattern low byte not stored.");
    pin_mode_a: assert property (wr_seq(ADDR_PIN_FUNC) ##0 !reg_wdata[0] ##1 !reg_wr [*2] |=> !pin_oe)
        else $error("Pin still driven in mode input setting.");
    osc_run_a: assert property (wr_seq(ADDR_LOW_RATE) ##0 reg_wdata[LR_RUN] ##1 !reg_wr |=> low_rate_oscillator)
        else $error("Run bit did not force the oscillator on.");
    pulldown_a: assert property (wr_seq(ADDR_LOW_RATE) |=> sdio_pulldown_en == !$past(reg_wdata[0]))
        else $error("Pull-down control does not follow its bit.");
    delay_max_a: assert property (wr_seq(ADDR_DELAY) ##0 (reg_wdata[DLY_CLK_EN] && reg_wdata[2:0] == 3'h7)
        ##1 !reg_wr |=> clk_delay_ps == 13'd4480)
        else $error("Largest clock delay is not 4.48 ns.");
    hold_read_a: assert property (wr_seq(ADDR_PAT1_LO) ##1 (!reg_wr [*2]) ##0 rd_seq(ADDR_PAT1_LO)
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3))
        else $error("Read back differs from the byte written.");
    reset_low_rate_a: assert property ($fell(rst) |-> st.regs.low_rate == RST_LOW_RATE)
        else $error("Low rate control not 0x08 after reset.");

endmodule // aoc_output_config
`default_nettype wire

// ==== hw/aoc_phase_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
module aoc_phase_sel
    import aoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] div_ratio,
    input wire logic [2:0] phase,
    output logic sample_en,
    output logic out_en
);

    aoc_phase_state_t st;
    aoc_phase_state_t next_st;
    logic [HIST_TAPS-1:0] taps;
    logic next_sample;

    // ------------------------------------------------------------
    // Divider and phase tap
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_sample = (st.cnt == div_ratio);
        next_st.cnt = next_sample ? 3'h0 : st.cnt + 3'h1;
        // Sampling strobe never depends on the phase setting.
        next_st.sample_en = next_sample;
        next_st.hist = {st.hist[4:0], st.sample_en};
        taps = {st.hist, st.sample_en, next_sample};
        // Output strobe lags the sampling strobe by phase input cycles.
        next_st.out_en = taps[phase];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sample_en = st.sample_en;
    assign out_en = st.out_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    phase_zero_a: assert property ((phase == 3'h0) && $stable(phase) |-> out_en == sample_en)
        else $error("Phase zero output strobe differs from sample strobe.");
    phase_three_a: assert property ((phase == 3'h3) [*4] |-> out_en == $past(sample_en, 3))
        else $error("Phase three output strobe is not three cycles late.");
    sample_period_a: assert property ((sample_en && div_ratio == 3'h2) ##1 (div_ratio == 3'h2) [*2]
        |-> !sample_en ##1 sample_en)
        else $error("Sample strobe period wrong for divide by three.");

endmodule // aoc_phase_sel
`default_nettype wire

// ==== hw/aoc_pkg.sv ====
package aoc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [12:0] ADDR_DRIVE = 13'h0015;
    localparam logic [12:0] ADDR_PHASE = 13'h0016;
    localparam logic [12:0] ADDR_DELAY = 13'h0017;
    localparam logic [12:0] ADDR_PAT1_LO = 13'h0019;
    localparam logic [12:0] ADDR_PAT1_HI = 13'h001a;
    localparam logic [12:0] ADDR_PAT2_LO = 13'h001b;
    localparam logic [12:0] ADDR_PAT2_HI = 13'h001c;
    localparam logic [12:0] ADDR_PIN_FUNC = 13'h002a;
    localparam logic [12:0] ADDR_LOW_RATE = 13'h0101;

    // ------------------------------------------------------------
    // Values after reset and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DRIVE = 8'h22;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [7:0] RST_PATTERN = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC = 8'h01;
    localparam logic [7:0] RST_LOW_RATE = 8'h08;
    localparam logic [7:0] MASK_PHASE = 8'h87;
    localparam logic [7:0] MASK_DELAY = 8'ha7;
    localparam logic [7:0] MASK_PIN_FUNC = 8'h01;
    localparam logic [7:0] MASK_LOW_RATE = 8'h0d;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DRV_CLK_3V3 = 6;
    localparam int DRV_CLK_1V8 = 4;
    localparam int DRV_DATA_3V3 = 2;
    localparam int DRV_DATA_1V8 = 0;
    localparam int PH_POLARITY = 7;
    localparam int DLY_CLK_EN = 7;
    localparam int DLY_DATA_EN = 5;
    localparam int PIN_OVERRANGE = 0;
    localparam int LR_DETECT_EN = 3;
    localparam int LR_RUN = 2;
    localparam int LR_PULLDOWN_OFF = 0;

    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam logic [12:0] DELAY_STEP_PS = 13'd560;
    localparam int HIST_TAPS = 8;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] phase;
        logic [7:0] delay;
        logic [7:0] pat1_lo;
        logic [7:0] pat1_hi;
        logic [7:0] pat2_lo;
        logic [7:0] pat2_hi;
        logic [7:0] pin_func;
        logic [7:0] low_rate;
    } aoc_regs_t;

    typedef struct packed {
        aoc_regs_t regs;
        logic [7:0] rdata;
        logic rvalid;
        logic [1:0] pin_sync;
        logic [1:0] slow_sync;
        logic mode_in;
        logic pin_out;
        logic pin_oe;
        logic osc_on;
        logic out_clk;
        logic sample_strobe;
        logic [2:0] clk_stripes;
        logic [2:0] data_stripes;
        logic [12:0] clk_delay_ps;
        logic [12:0] data_delay_ps;
    } aoc_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [5:0] hist;
        logic sample_en;
        logic out_en;
    } aoc_phase_state_t;

endpackage

// ==== sim/tb_aoc_output_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_aoc_output_config
    import aoc_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, io_supply_1v8, overrange, slow_clock_detected, pin_in;
    logic [12:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, got;
    logic [2:0] div_ratio, clk_drive_stripes, data_drive_stripes;
    logic reg_rvalid, pin_out, pin_oe, mode_in, sample_strobe, output_sample_clock;
    logic detect_enable, low_rate_oscillator, sdio_pulldown_en;
    logic [12:0] clk_delay_ps, data_delay_ps;
    logic [15:0] pattern_one, pattern_two;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int lag, per;
    // ------------------------------------------------------------
    // Rows: address, byte written, readback expected, value after reset
    // ------------------------------------------------------------
    logic [12:0] row_addr [10] = '{13'h015, 13'h016, 13'h017, 13'h019, 13'h01a, 13'h01b, 13'h01c,
                                   13'h02a, 13'h101, 13'h018};
    logic [7:0] row_wd [10] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'hff, 8'hff, 8'hff};
    logic [7:0] row_rb [10] = '{8'hff, 8'h87, 8'ha7, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h01, 8'h0d, 8'h00};
    logic [7:0] row_rst [10] = '{8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00};

    aoc_output_config u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .div_ratio(div_ratio),
        .io_supply_1v8(io_supply_1v8), .overrange(overrange), .slow_clock_detected(slow_clock_detected),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mode_in(mode_in),
        .sample_strobe(sample_strobe), .output_sample_clock(output_sample_clock),
        .clk_drive_stripes(clk_drive_stripes), .data_drive_stripes(data_drive_stripes),
        .clk_delay_ps(clk_delay_ps), .data_delay_ps(data_delay_ps), .pattern_one(pattern_one),
        .pattern_two(pattern_two), .detect_enable(detect_enable),
        .low_rate_oscillator(low_rate_oscillator), .sdio_pulldown_en(sdio_pulldown_en));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
        d = reg_rdata;
    endtask

    // Derived outputs trail the write edge by two cycles, so four is safe.
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic check_resets();
        for (int i = 0; i < 10; i++) begin
            rd(row_addr[i], got);
            chk("reset value", {8'h0, got}, {8'h0, row_rst[i]});
        end
    endtask

    // Lag from a sample strobe to the output clock, and strobe period.
    task automatic measure();
        int i;
        lag = -1;
        per = -1;
        for (i = 0; i < 40 && sample_strobe !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        for (i = 0; i < 20; i++) begin
            if (output_sample_clock === 1'b1 && lag < 0) lag = i;
            @(posedge clk);
            #1;
            if (sample_strobe === 1'b1 && per < 0) per = i + 1;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 13'h000; reg_wdata = 8'h00;
        div_ratio = 3'h7; io_supply_1v8 = 1'b0; overrange = 1'b0; slow_clock_detected = 1'b0; pin_in = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        check_resets();
        settle();
        chk("detect en", {15'h0, detect_enable}, 16'h0001);
        chk("pulldown", {15'h0, sdio_pulldown_en}, 16'h0001);
        chk("pin oe", {15'h0, pin_oe}, 16'h0001);
        for (int i = 0; i < 10; i++) begin
            wr(row_addr[i], row_wd[i]);
            rd(row_addr[i], got);
            chk("readback", {8'h0, got}, {8'h0, row_rb[i]});
        end
        settle();
        chk("pattern one", pattern_one, 16'h5aa5);
        chk("pattern two", pattern_two, 16'hc33c);
        chk("osc forced", {15'h0, low_rate_oscillator}, 16'h0001);
        chk("pulldown off", {15'h0, sdio_pulldown_en}, 16'h0000);
        // Read and write in one cycle must return the old byte.
        @(posedge clk);
        reg_wr <= 1'b1; reg_rd <= 1'b1; reg_addr <= 13'h019; reg_wdata <= 8'h11;
        @(posedge clk);
        reg_wr <= 1'b0; reg_rd <= 1'b0;
        #1;
        chk("rd old", {8'h0, reg_rdata}, 16'h00a5);
        settle();
        chk("pattern new", pattern_one, 16'h5a11);
        // High byte then low byte in back-to-back cycles.
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= 13'h01a; reg_wdata <= 8'h77;
        @(posedge clk);
        reg_addr <= 13'h019; reg_wdata <= 8'h66;
        @(posedge clk);
        reg_wr <= 1'b0;
        settle();
        chk("pattern pair", pattern_one, 16'h7766);
        // Detector path with the run bit clear.
        wr(13'h101, 8'h08);
        slow_clock_detected <= 1'b1;
        settle();
        chk("osc detect", {15'h0, low_rate_oscillator}, 16'h0001);
        wr(13'h101, 8'h00);
        settle();
        chk("osc no detect", {15'h0, low_rate_oscillator}, 16'h0000);
        // Drive strength fields for both pad supplies.
        wr(13'h015, 8'he4);
        settle();
        chk("clk drv 3v3", {13'h0, clk_drive_stripes}, 16'h0004);
        chk("data drv 3v3", {13'h0, data_drive_stripes}, 16'h0002);
        io_supply_1v8 <= 1'b1;
        settle();
        chk("clk drv 1v8", {13'h0, clk_drive_stripes}, 16'h0003);
        chk("data drv 1v8", {13'h0, data_drive_stripes}, 16'h0001);
        wr(13'h015, 8'h33);
        settle();
        chk("clk drv max", {13'h0, clk_drive_stripes}, 16'h0004);
        chk("data drv max", {13'h0, data_drive_stripes}, 16'h0004);
        // Fine delay codes, then the clock enable alone.
        for (int c = 0; c < 8; c++) begin
            wr(13'h017, 8'ha0 | 8'(c));
            settle();
            chk("clk delay", {3'h0, clk_delay_ps}, 16'((c + 1) * 560));
            chk("data delay", {3'h0, data_delay_ps}, 16'((c + 1) * 560));
        end
        wr(13'h017, 8'h83);
        settle();
        chk("clk only", {3'h0, clk_delay_ps}, 16'd2240);
        chk("data off", {3'h0, data_delay_ps}, 16'h0000);
        // Every phase code with divide by eight; sampling period must not move.
        for (int p = 0; p < 8; p++) begin
            wr(13'h016, 8'(p));
            settle();
            measure();
            chk("phase lag", 16'(lag), 16'(p));
            chk("strobe period", 16'(per), 16'h0008);
        end
        wr(13'h016, 8'h80);
        settle();
        measure();
        chk("inverted clk", 16'(lag), 16'h0001);
        div_ratio <= 3'h2;
        settle();
        measure();
        chk("div three", 16'(per), 16'h0003);
        div_ratio <= 3'h0;
        settle();
        measure();
        chk("div one", 16'(per), 16'h0001);
        // Shared pin as mode input, then as overrange output.
        wr(13'h02a, 8'h00);
        pin_in <= 1'b1;
        overrange <= 1'b1;
        settle();
        chk("mode oe", {15'h0, pin_oe}, 16'h0000);
        chk("mode in", {15'h0, mode_in}, 16'h0001);
        chk("mode out", {15'h0, pin_out}, 16'h0000);
        wr(13'h02a, 8'h01);
        settle();
        chk("or out", {15'h0, pin_out}, 16'h0001);
        chk("or mode", {15'h0, mode_in}, 16'h0000);
        // A second reset in mid-run restores every register.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_resets();
        end_sim();
    end
endmodule // tb_aoc_output_config
`default_nettype wire
